// [svs_defs.svh]
// register offsets, field positions and reset values for the supply sensor
// assumes byte-wide registers at the printed offsets on a plain strobe port
`ifndef SVS_DEFS_SVH
`define SVS_DEFS_SVH

`define SVS_ADDR_W        3
`define SVS_OFS_ENABLE    3'h0
`define SVS_OFS_STATUS    3'h1
`define SVS_OFS_IRQ_EN    3'h2
`define SVS_OFS_FLAGS     3'h3
`define SVS_OFS_RSVD_LO   3'h4
`define SVS_OFS_RSVD_HI   3'h5
`define SVS_OFS_TEST_LO   3'h6
`define SVS_OFS_TEST_HI   3'h7

`define SVS_BIT_BAT_SENSE 0
`define SVS_BIT_BAT_ADC   1
`define SVS_BIT_SUP_SENSE 2
`define SVS_BIT_SUP_ADC   3
`define SVS_BIT_LOW_SEL   4
`define SVS_BIT_HIGH_SEL  6
`define SVS_BIT_LOW       0
`define SVS_BIT_HIGH      1

`define SVS_ENABLE_RST    8'h00
`define SVS_IRQ_EN_RST    8'h00
`define SVS_FLAGS_RST     8'h00
`define SVS_TEST_RST      8'h00

`endif

// [svs_pkg.sv]
// types shared by the supply sensor control block
package svs_pkg;

	typedef enum logic [1:0]
	{
		SVS_SRC_NONE    = 2'b00,
		SVS_SRC_BATTERY = 2'b01,
		SVS_SRC_SUPPLY  = 2'b10
	} svs_src_t;

	// analog-facing controls bundled together
	typedef struct packed
	{
		logic     battery_path_closed;
		logic     supply_path_closed;
		svs_src_t cmp_src;
		svs_src_t adc_src;
		logic     cmp_enable;
		logic     high_level_select;
		logic [1:0] low_level_select;
	} svs_analog_ctl_t;

endpackage

// [svs_ctrl.sv]
// supply_sensor control: enable config, condition status, change flags, irq
// assumes comparator outputs are asynchronous and the bus strobes are on clk
//
// Functional notes
// - battery level-sense enable wins over supply enable for comparator source
// - battery adc connect wins over supply adc connect for adc source
// - in run mode a pin's divider closes if its sense or adc enable set
// - stop mode opens both dividers, disables sensing, keeps config bits
// - unimplemented bits of the register space read zero
// - enable bit 6 picks high trigger level one or two
// - enable bits 5:4 pick low trigger level one to four
// - supply adc connect can be set only while battery adc connect clear
// - supply sense enable can be set only while battery sense enable clear
// - setting battery adc connect clears supply adc connect
// - setting battery sense enable clears supply sense enable
// - status register readable anytime, writes ignored
// - status bit 1 shows comparator high condition
// - status bit 0 shows comparator low condition
// - high-change flag sets on any high condition change
// - low-change flag sets on any low condition change
// - flags clear only by writing one; zero leaves them
// - high flag with high enable requests interrupt
// - low flag with low enable requests interrupt
// - test registers writable only in special mode
// - both sense enables clear forces condition bits to zero
// - high and low requests ORed into one interrupt output
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`include "svs_defs.svh"

// surroundings assumed by this block:
// - register strobes come from logic on clk, one cycle each, never both
// - stop_mode and special_mode are levels from logic on clk, no sync
// - comparator outputs are free-running analog edges, synchronised here
// - settling after a path change is left to software, nothing waits here

module svs_ctrl
(
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   srst,
	// register port
	input  wire logic [`SVS_ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]             reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output      logic [7:0]             reg_rdata,
	// system modes
	input  wire logic                   stop_mode,
	input  wire logic                   special_mode,
	// analog comparator, asynchronous
	input  wire logic                   cmp_high_async,
	input  wire logic                   cmp_low_async,
	// analog controls
	output      svs_pkg::svs_analog_ctl_t analog_ctl,
	output      logic [15:0]            factory_test,
	// interrupt
	output      logic                   sensor_irq_out
);

	////////////////////////////////////////////////////////////////////////
	// configuration registers

	logic                   high_level_select_ff;
	logic [1:0]             low_level_select_ff;
	logic                   supply_adc_connect_ff;
	logic                   supply_level_sense_en_ff;
	logic                   battery_adc_connect_ff;
	logic                   battery_level_sense_en_ff;
	logic                   high_change_irq_en_ff;
	logic                   low_change_irq_en_ff;
	logic [15:0]            factory_test_ff;

	logic                   wr_enable;
	logic                   wr_irq_en;
	logic                   wr_flags;
	logic                   wr_test_lo;
	logic                   wr_test_hi;
	logic [7:0]             enable_rd;

	assign wr_enable  = reg_wr && (reg_addr == `SVS_OFS_ENABLE);
	assign wr_irq_en  = reg_wr && (reg_addr == `SVS_OFS_IRQ_EN);
	assign wr_flags   = reg_wr && (reg_addr == `SVS_OFS_FLAGS);
	assign wr_test_lo = reg_wr && special_mode && (reg_addr == `SVS_OFS_TEST_LO);
	assign wr_test_hi = reg_wr && special_mode && (reg_addr == `SVS_OFS_TEST_HI);

	// battery bits are written first; supply bits see the new battery value,
	// so writing both at once leaves only the battery enable set
	//
	// a supply bit is refused in two cases:
	// - the same write sets the battery bit of that kind
	// - the battery bit of that kind is already set
	// the refusal is silent; software reads back to see what stuck.
	// clearing the battery bit and setting the supply bit needs two writes,
	// which keeps the comparator source from flipping inside one write
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			high_level_select_ff      <= 1'b0;
			low_level_select_ff       <= 2'h0;
			battery_adc_connect_ff    <= 1'b0;
			battery_level_sense_en_ff <= 1'b0;
			supply_adc_connect_ff     <= 1'b0;
			supply_level_sense_en_ff  <= 1'b0;
		end
		else if (wr_enable)
		begin
			high_level_select_ff      <= reg_wdata[`SVS_BIT_HIGH_SEL];
			low_level_select_ff       <= reg_wdata[`SVS_BIT_LOW_SEL +: 2];
			battery_adc_connect_ff    <= reg_wdata[`SVS_BIT_BAT_ADC];
			battery_level_sense_en_ff <= reg_wdata[`SVS_BIT_BAT_SENSE];
			supply_adc_connect_ff     <= reg_wdata[`SVS_BIT_SUP_ADC]
				&& !reg_wdata[`SVS_BIT_BAT_ADC] && !battery_adc_connect_ff;
			supply_level_sense_en_ff  <= reg_wdata[`SVS_BIT_SUP_SENSE]
				&& !reg_wdata[`SVS_BIT_BAT_SENSE] && !battery_level_sense_en_ff;
		end
	end

	// irq enables gate the request only; flags keep setting while disabled,
	// so enabling later raises the request for an old change at once

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			high_change_irq_en_ff <= 1'b0;
			low_change_irq_en_ff  <= 1'b0;
		end
		else if (wr_irq_en)
		begin
			high_change_irq_en_ff <= reg_wdata[`SVS_BIT_HIGH];
			low_change_irq_en_ff  <= reg_wdata[`SVS_BIT_LOW];
		end
	end

	// factory test pair: bytes are written independently, low at the even
	// offset and high at the odd one; outside special mode writes are
	// dropped, reads still return the stored contents

	always_ff @(posedge clk)
	begin
		if (srst)
			factory_test_ff <= {`SVS_TEST_RST, `SVS_TEST_RST};
		else
		begin
			if (wr_test_lo)
				factory_test_ff[7:0] <= reg_wdata;
			if (wr_test_hi)
				factory_test_ff[15:8] <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// analog control outputs, registered; stop mode never touches config bits

	logic                     sense_any;
	svs_pkg::svs_analog_ctl_t nxt_analog_ctl;
	svs_pkg::svs_analog_ctl_t analog_ctl_ff;

	// registered outputs cost one cycle of lag after a config write, but
	// keep the analog switches free of decode glitches.
	// stop mode is applied here and in the condition status, the config flops are left alone,
	// so leaving stop restores the paths without software help

	assign sense_any = battery_level_sense_en_ff || supply_level_sense_en_ff;

	always_comb
	begin
		nxt_analog_ctl = '0;
		nxt_analog_ctl.battery_path_closed = !stop_mode
			&& (battery_level_sense_en_ff || battery_adc_connect_ff);
		nxt_analog_ctl.supply_path_closed  = !stop_mode
			&& (supply_level_sense_en_ff || supply_adc_connect_ff);
		nxt_analog_ctl.cmp_enable          = !stop_mode && sense_any;
		if (stop_mode)
			nxt_analog_ctl.cmp_src = svs_pkg::SVS_SRC_NONE;
		else if (battery_level_sense_en_ff)
			nxt_analog_ctl.cmp_src = svs_pkg::SVS_SRC_BATTERY;
		else if (supply_level_sense_en_ff)
			nxt_analog_ctl.cmp_src = svs_pkg::SVS_SRC_SUPPLY;
		else
			nxt_analog_ctl.cmp_src = svs_pkg::SVS_SRC_NONE;
		if (stop_mode)
			nxt_analog_ctl.adc_src = svs_pkg::SVS_SRC_NONE;
		else if (battery_adc_connect_ff)
			nxt_analog_ctl.adc_src = svs_pkg::SVS_SRC_BATTERY;
		else if (supply_adc_connect_ff)
			nxt_analog_ctl.adc_src = svs_pkg::SVS_SRC_SUPPLY;
		else
			nxt_analog_ctl.adc_src = svs_pkg::SVS_SRC_NONE;
		nxt_analog_ctl.high_level_select   = high_level_select_ff;
		nxt_analog_ctl.low_level_select    = low_level_select_ff;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			analog_ctl_ff <= '0;
		else
			analog_ctl_ff <= nxt_analog_ctl;
	end

	assign analog_ctl   = analog_ctl_ff;
	assign factory_test = factory_test_ff;

	////////////////////////////////////////////////////////////////////////
	// comparator synchroniser and condition status

	// both comparator bits share one two-flop chain; the two bits are
	// independent conditions, so a skew of one cycle between them is fine.
	// only the second stage feeds status and change detection, which
	// keeps a metastable first stage from ever setting a flag twice

	logic [1:0]             cmp_meta_ff;
	logic [1:0]             cmp_sync_ff;
	logic                   high_condition_ff;
	logic                   low_condition_ff;
	logic                   nxt_high_condition;
	logic                   nxt_low_condition;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cmp_meta_ff <= 2'h0;
			cmp_sync_ff <= 2'h0;
		end
		else
		begin
			cmp_meta_ff <= {cmp_high_async, cmp_low_async};
			cmp_sync_ff <= cmp_meta_ff;
		end
	end

	// forced low whenever sensing is off, also in stop mode
	assign nxt_high_condition = sense_any && !stop_mode && cmp_sync_ff[1];
	assign nxt_low_condition  = sense_any && !stop_mode && cmp_sync_ff[0];

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			high_condition_ff <= 1'b0;
			low_condition_ff  <= 1'b0;
		end
		else
		begin
			high_condition_ff <= nxt_high_condition;
			low_condition_ff  <= nxt_low_condition;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// change flags: a change in the clear cycle wins over the clear

	// changes are seen on the next status value against the current one,
	// so the flag rises on the same edge as the status bit.
	// a clear written in the cycle of a new change is lost on purpose:
	// software would otherwise miss that change entirely.
	// a write of zero to a flag bit leaves it untouched

	logic                   high_change_flag_ff;
	logic                   low_change_flag_ff;
	logic                   high_changed;
	logic                   low_changed;

	assign high_changed = nxt_high_condition != high_condition_ff;
	assign low_changed  = nxt_low_condition != low_condition_ff;

	always_ff @(posedge clk)
	begin
		if (srst)
			high_change_flag_ff <= 1'b0;
		else if (high_changed)
			high_change_flag_ff <= 1'b1;
		else if (wr_flags && reg_wdata[`SVS_BIT_HIGH])
			high_change_flag_ff <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			low_change_flag_ff <= 1'b0;
		else if (low_changed)
			low_change_flag_ff <= 1'b1;
		else if (wr_flags && reg_wdata[`SVS_BIT_LOW])
			low_change_flag_ff <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt, one cycle behind the flags

	// one combined request; software reads the flags to tell the causes
	// apart. the lag of one cycle behind the flags keeps the output a
	// plain flop

	logic                   irq_ff;

	always_ff @(posedge clk)
	begin
		if (srst)
			irq_ff <= 1'b0;
		else
			irq_ff <= (high_change_flag_ff && high_change_irq_en_ff)
				|| (low_change_flag_ff && low_change_irq_en_ff);
	end

	assign sensor_irq_out = irq_ff;

	////////////////////////////////////////////////////////////////////////
	// read port; data valid the cycle after the strobe

	// address decode runs every cycle; the strobe only picks whether the
	// result is kept. unused offsets and unused bits decode to zero.
	// reading has no side effect on any flag

	logic [7:0]             nxt_rdata;
	logic [7:0]             rdata_ff;

	assign enable_rd = {1'b0, high_level_select_ff, low_level_select_ff,
		supply_adc_connect_ff, supply_level_sense_en_ff,
		battery_adc_connect_ff, battery_level_sense_en_ff};

	always_comb
	begin
		nxt_rdata = 8'h00;
		if (reg_addr == `SVS_OFS_ENABLE)
			nxt_rdata = enable_rd;
		else if (reg_addr == `SVS_OFS_STATUS)
			nxt_rdata = {6'h00, high_condition_ff, low_condition_ff};
		else if (reg_addr == `SVS_OFS_IRQ_EN)
			nxt_rdata = {6'h00, high_change_irq_en_ff, low_change_irq_en_ff};
		else if (reg_addr == `SVS_OFS_FLAGS)
			nxt_rdata = {6'h00, high_change_flag_ff, low_change_flag_ff};
		else if (reg_addr == `SVS_OFS_TEST_LO)
			nxt_rdata = factory_test_ff[7:0];
		else if (reg_addr == `SVS_OFS_TEST_HI)
			nxt_rdata = factory_test_ff[15:8];
	end

	// read data drops to zero outside the cycle after a read
	always_ff @(posedge clk)
	begin
		if (srst)
			rdata_ff <= 8'h00;
		else if (reg_rd)
			rdata_ff <= nxt_rdata;
		else
			rdata_ff <= 8'h00;
	end

	assign reg_rdata = rdata_ff;

endmodule

// [svs_ctrl_props.sv]
// checker for svs_ctrl port behaviour
// mirrors the enable and irq-enable writes to predict outputs
`timescale 1ns/10ps
`include "svs_defs.svh"

module svs_ctrl_props
(
	// clock and reset
	input wire logic                     clk,
	input wire logic                     srst,
	// register port
	input wire logic [`SVS_ADDR_W-1:0]   reg_addr,
	input wire logic [7:0]               reg_wdata,
	input wire logic                     reg_wr,
	input wire logic                     reg_rd,
	input wire logic [7:0]               reg_rdata,
	// modes and outputs
	input wire logic                     stop_mode,
	input wire svs_pkg::svs_analog_ctl_t analog_ctl,
	input wire logic                     sensor_irq_out
);
	logic [6:0]        en_ff;
	logic [1:0]        ie_ff;
	logic [6:0]        nxt_en;
	svs_pkg::svs_src_t exp_cmp;
	svs_pkg::svs_src_t exp_adc;

	// supply bits refused while battery bit written or held
	always_comb
	begin
		nxt_en = {reg_wdata[6:4], reg_wdata[3] & ~reg_wdata[1] & ~en_ff[1],
			reg_wdata[2] & ~reg_wdata[0] & ~en_ff[0], reg_wdata[1:0]};
		exp_cmp = en_ff[0] ? svs_pkg::SVS_SRC_BATTERY :
			en_ff[2] ? svs_pkg::SVS_SRC_SUPPLY : svs_pkg::SVS_SRC_NONE;
		exp_adc = en_ff[1] ? svs_pkg::SVS_SRC_BATTERY :
			en_ff[3] ? svs_pkg::SVS_SRC_SUPPLY : svs_pkg::SVS_SRC_NONE;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			en_ff <= 7'h00;
		else if (reg_wr && reg_addr == 3'h0)
			en_ff <= nxt_en;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			ie_ff <= 2'h0;
		else if (reg_wr && reg_addr == 3'h2)
			ie_ff <= reg_wdata[1:0];
	end

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	sequence cfg_read_s;
		reg_rd && reg_addr == 3'h0;
	endsequence
	sequence rsvd_read_s;
		reg_rd && (reg_addr == 3'h4 || reg_addr == 3'h5);
	endsequence

	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside read");
	cfg_readback_a: assert property (cfg_read_s |=> reg_rdata == {1'b0, $past(en_ff)})
		else $error("enable register readback wrong");
	rsvd_zero_a: assert property (rsvd_read_s |=> reg_rdata == 8'h00)
		else $error("reserved bytes not zero");
	cmp_source_a: assert property (!stop_mode |=> analog_ctl.cmp_src == $past(exp_cmp))
		else $error("comparator source wrong");
	adc_source_a: assert property (!stop_mode |=> analog_ctl.adc_src == $past(exp_adc))
		else $error("adc source wrong");
	path_close_a: assert property (!stop_mode |=> analog_ctl.battery_path_closed ==
		($past(en_ff[0]) | $past(en_ff[1])) && analog_ctl.supply_path_closed ==
		($past(en_ff[2]) | $past(en_ff[3])) && analog_ctl.cmp_enable ==
		($past(en_ff[0]) | $past(en_ff[2])))
		else $error("divider path state wrong");
	stop_open_a: assert property (stop_mode |=> !analog_ctl.battery_path_closed &&
		!analog_ctl.supply_path_closed && !analog_ctl.cmp_enable)
		else $error("paths not open in stop");
	level_sel_a: assert property (analog_ctl.high_level_select == $past(en_ff[6]) &&
		analog_ctl.low_level_select == $past(en_ff[5:4]))
		else $error("trigger level select wrong");
	irq_gate_a: assert property (sensor_irq_out |-> $past(ie_ff) != 2'h0)
		else $error("interrupt without enable");
endmodule

bind svs_ctrl svs_ctrl_props u_svs_ctrl_props
(
	.clk            (clk),
	.srst           (srst),
	.reg_addr       (reg_addr),
	.reg_wdata      (reg_wdata),
	.reg_wr         (reg_wr),
	.reg_rd         (reg_rd),
	.reg_rdata      (reg_rdata),
	.stop_mode      (stop_mode),
	.analog_ctl     (analog_ctl),
	.sensor_irq_out (sensor_irq_out)
);

// [svs_cmp_model.sv]
// behavioural analog comparator on the selected sense pin
// bench sets the wanted conditions; outputs change off the clock
`timescale 1ns/10ps

module svs_cmp_model
(
	input  wire svs_pkg::svs_analog_ctl_t analog_ctl,
	input  wire logic                     want_high,
	input  wire logic                     want_low,
	output      logic                     cmp_high_async,
	output      logic                     cmp_low_async
);
	// a powered-down comparator reads low, never unknown
	assign #3 cmp_high_async = want_high & analog_ctl.cmp_enable;
	assign #3 cmp_low_async  = want_low & analog_ctl.cmp_enable;
endmodule

// [test_svs_ctrl.sv]
// self-checking bench for svs_ctrl over its byte register port
// assumes svs_cmp_model drives the comparator inputs
`timescale 1ns/10ps
`include "svs_defs.svh"

module test_svs_ctrl;
	logic                     clk = 1'b0;
	logic                     srst = 1'b1;
	logic [`SVS_ADDR_W-1:0]   reg_addr = 3'h0;
	logic [7:0]               reg_wdata = 8'h00;
	logic                     reg_wr = 1'b0;
	logic                     reg_rd = 1'b0;
	logic                     stop_mode = 1'b0;
	logic                     special_mode = 1'b0;
	logic                     want_high = 1'b0;
	logic                     want_low = 1'b0;
	logic [7:0]               reg_rdata;
	logic                     cmp_high_async;
	logic                     cmp_low_async;
	svs_pkg::svs_analog_ctl_t analog_ctl;
	logic [15:0]              factory_test;
	logic                     sensor_irq_out;
	logic [7:0]               v;
	int                       error_cnt = 0;
	int                       n_compared = 0;

	always #2 clk = ~clk;

	svs_ctrl u_svs_ctrl (.clk(clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .stop_mode(stop_mode), .special_mode(special_mode),
		.cmp_high_async(cmp_high_async), .cmp_low_async(cmp_low_async),
		.analog_ctl(analog_ctl), .factory_test(factory_test),
		.sensor_irq_out(sensor_irq_out));
	svs_cmp_model u_svs_cmp_model (.analog_ctl(analog_ctl), .want_high(want_high),
		.want_low(want_low), .cmp_high_async(cmp_high_async),
		.cmp_low_async(cmp_low_async));

	////////////////////////////////////////////////////////////////////////////
	task results;
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task chk8(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t byte %h expected %h", $time, got, exp);
		end
	endtask

	task chk1(input logic got, input logic exp);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t bit %b expected %b", $time, got, exp);
		end
	endtask

	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk8(reg_rdata, exp);
	endtask

	task wait_irq(input logic exp);
		for (int i = 0; i < 20; i++)
		begin
			#1;
			if (sensor_irq_out === exp)
				break;
			@(posedge clk);
		end
		chk1(sensor_irq_out, exp);
		if (sensor_irq_out !== exp)
			results();
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		for (int a = 0; a < 8; a++)
			rd(a[2:0], 8'h00);
		wr(3'h0, 8'h0c);
		rd(3'h0, 8'h0c);
		wr(3'h0, 8'h0f);
		rd(3'h0, 8'h03);
		wr(3'h0, 8'h0c);
		rd(3'h0, 8'h00);
		for (int c = 0; c < 4; c++)
		begin
			v = {1'b0, c[0], c[1:0], 4'h0};
			wr(3'h0, v);
			rd(3'h0, v);
		end
		$display("test config done");
		wr(3'h1, 8'hff);
		rd(3'h1, 8'h00);
		wr(3'h4, 8'hff);
		rd(3'h4, 8'h00);
		wr(3'h6, 8'ha5);
		rd(3'h6, 8'h00);
		@(posedge clk);
		special_mode <= 1'b1;
		wr(3'h6, 8'ha5);
		wr(3'h7, 8'h3c);
		rd(3'h6, 8'ha5);
		rd(3'h7, 8'h3c);
		chk8(factory_test[15:8], 8'h3c);
		$display("test reserved done");
		wr(3'h0, 8'h01);
		wr(3'h2, 8'h03);
		repeat (4) @(posedge clk);
		want_high <= 1'b1;
		wait_irq(1'b1);
		rd(3'h1, 8'h02);
		wr(3'h3, 8'h00);
		rd(3'h3, 8'h02);
		wr(3'h3, 8'h02);
		rd(3'h3, 8'h00);
		wait_irq(1'b0);
		@(posedge clk);
		want_high <= 1'b0;
		want_low <= 1'b1;
		wait_irq(1'b1);
		rd(3'h1, 8'h01);
		rd(3'h3, 8'h03);
		wr(3'h2, 8'h02);
		wr(3'h3, 8'h02);
		wait_irq(1'b0);
		wr(3'h2, 8'h01);
		wait_irq(1'b1);
		$display("test condition done");
		wr(3'h3, 8'h03);
		wr(3'h0, 8'h00);
		wait_irq(1'b1);
		rd(3'h1, 8'h00);
		rd(3'h3, 8'h01);
		wr(3'h3, 8'h03);
		wr(3'h0, 8'h01);
		wait_irq(1'b1);
		wr(3'h3, 8'h03);
		wait_irq(1'b0);
		@(posedge clk);
		stop_mode <= 1'b1;
		wait_irq(1'b1);
		rd(3'h0, 8'h01);
		rd(3'h1, 8'h00);
		chk1(analog_ctl.battery_path_closed, 1'b0);
		@(posedge clk);
		stop_mode <= 1'b0;
		$display("test stop done");
		results();
	end
endmodule
